//--- design/ping_trigger_scheduler.v
// ping trigger scheduler: source select, ping sequencing, interleave and lamp
// ----------------------------------------------------------------------------
// Operation
// [R01] ping start comes from exactly one selected source: timer, command or hw line
// [R02] timer source pings at configured integer rate one to eight per second
// [R03] hw trigger edge selectable: rising only, falling only, or both
// [R04] each accepted trigger runs transmit then receive before watching again
// [R05] triggers during a ping are dropped, never queued
// [R06] hw triggers faster than range-implied minimum interval are ignored
// [R07] controller holds each hw trigger pulse at least one millisecond
// [R08] transmit starts 8.4 ms after an accepted trigger
// [R09] transmit capped 13.3 or 26.6 ms by variant, shortened by bottom distance
// [R10] sample rate setting only used with the timer source
// [R11] command source pings on a command from ethernet or serial link
// [R12] every Nth ping is profile when profiling enabled, others bottom track
// [R13] water track rides on the bottom-track ping, losing none
// [R14] recording appends to an existing file of the same name
// [R15] storage full stops writing but measurement and output go on
// [R16] transmit power is automatic maximum or user value, 0 dB full power
// [R17] lamp flashes once per ping while measuring; pings closer than the lamp on time merge into one glow
// [R18] configuration and measuring state kept over power loss, resumed on power-up
// [R19] after power-up while measuring, pinging pauses about one to two seconds
// [R20] hw trigger passes a multi-stage synchroniser before edge detection
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`include "ping_sched_consts.vh"

module ping_trigger_scheduler #(
  parameter [31:0] TX_DELAY_CYC_P     = `TX_DELAY_CYC,
  parameter [31:0] TX_MAX_HI_CYC_P    = `TX_MAX_HI_CYC,
  parameter [31:0] TX_MAX_LO_CYC_P    = `TX_MAX_LO_CYC,
  parameter [31:0] RESUME_PAUSE_CYC_P = `RESUME_PAUSE_CYC,
  parameter [31:0] LAMP_ON_CYC_P      = `LAMP_ON_CYC,
  parameter [31:0] SECOND_CYC_P       = `CLK_HZ
) (
  input  wire                CLK_IN,
  input  wire                SYS_RST_IN,
  input  wire                MEASURE_EN_IN,
  input  wire                STORED_MEASURE_IN,
  input  wire [1:0]          TRIG_SRC_IN,
  input  wire [`RATE_W-1:0]  SAMPLE_RATE_IN,
  input  wire [1:0]          EDGE_SEL_IN,
  input  wire                HW_TRIG_IN,
  input  wire                ETH_CMD_TRIG_IN,
  input  wire                SER_CMD_TRIG_IN,
  input  wire [`CNT_W-1:0]   MIN_INTERVAL_CYC_IN,
  input  wire                LOW_FREQ_VARIANT_IN,
  input  wire [`CNT_W-1:0]   TX_LEN_CYC_IN,
  input  wire [`CNT_W-1:0]   RX_LEN_CYC_IN,
  input  wire                PROFILE_EN_IN,
  input  wire [`ILV_W-1:0]   ILV_RATIO_IN,
  input  wire                WATER_TRACK_EN_IN,
  input  wire                REC_EN_IN,
  input  wire                FILE_EXISTS_IN,
  input  wire                STORAGE_FULL_IN,
  input  wire                PWR_AUTO_IN,
  input  wire [`PWR_W-1:0]   PWR_USER_DB_IN,
  input  wire [`PWR_W-1:0]   PWR_MAX_DB_IN,
  output reg                 TX_ACTIVE_OUT,
  output reg                 RX_ACTIVE_OUT,
  output reg                 PING_BUSY_OUT,
  output reg                 PING_START_OUT,
  output reg                 PROFILE_PING_OUT,
  output reg                 BOTTOM_PING_OUT,
  output reg                 WATER_TRACK_OUT,
  output reg                 REC_WRITE_EN_OUT,
  output reg                 REC_APPEND_OUT,
  output reg [`PWR_W-1:0]    TX_PWR_DB_OUT,
  output reg                 LAMP_OUT,
  output reg                 MEASURING_OUT,
  output reg                 TRIG_DROPPED_OUT
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_TX    = 3'h2;
  localparam [2:0] ST_RX    = 3'h3;
  localparam [2:0] ST_PAUSE = 3'h4;

  // ----------------------------------------------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------------------------------------------
  reg [`SYNC_STAGES-1:0] sync_reg;
  reg                    hw_prev_reg;
  wire                   hw_sync = sync_reg[`SYNC_STAGES-1];

  // first stage only feeds the second, edge logic looks at the last stage
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sync_reg    <= {`SYNC_STAGES{1'b0}};
      hw_prev_reg <= 1'b0;
    end else begin
      sync_reg    <= {sync_reg[`SYNC_STAGES-2:0], HW_TRIG_IN}; // [R20]
      hw_prev_reg <= hw_sync;
    end
  end

  wire rise = hw_sync & ~hw_prev_reg;
  wire fall = ~hw_sync & hw_prev_reg;
  reg  hw_edge;
  always @* begin
    case (EDGE_SEL_IN) // [R03]
      `EDGE_RISE: hw_edge = rise;
      `EDGE_FALL: hw_edge = fall;
      `EDGE_BOTH: hw_edge = rise | fall;
      default:    hw_edge = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // internal rate timer
  // ----------------------------------------------------------------------------
  reg  [`CNT_W-1:0]  rate_cnt_reg;
  wire [`RATE_W-1:0] rate_lim = (SAMPLE_RATE_IN == {`RATE_W{1'b0}}) ? 4'h1 :
                                (SAMPLE_RATE_IN > 4'h8) ? 4'h8 : SAMPLE_RATE_IN; // [R02]
  // eight fixed periods, so no run-time divider sits on the rate setting
  reg  [`CNT_W-1:0]  rate_period;
  always @* begin
    case (rate_lim) // [R02]
      4'h1:    rate_period = SECOND_CYC_P;
      4'h2:    rate_period = SECOND_CYC_P / 32'h2;
      4'h3:    rate_period = SECOND_CYC_P / 32'h3;
      4'h4:    rate_period = SECOND_CYC_P / 32'h4;
      4'h5:    rate_period = SECOND_CYC_P / 32'h5;
      4'h6:    rate_period = SECOND_CYC_P / 32'h6;
      4'h7:    rate_period = SECOND_CYC_P / 32'h7;
      4'h8:    rate_period = SECOND_CYC_P / 32'h8;
      default: rate_period = SECOND_CYC_P;
    endcase
  end
  wire               timer_on = (TRIG_SRC_IN == `SRC_TIMER); // [R10]
  wire               timer_tick = timer_on && (rate_cnt_reg >= rate_period - 32'h1);

  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      rate_cnt_reg <= {`CNT_W{1'b0}};
    else if (!timer_on || !MEASURING_OUT || timer_tick)
      rate_cnt_reg <= {`CNT_W{1'b0}}; // [R10]
    else
      rate_cnt_reg <= rate_cnt_reg + 32'h1;
  end

  // ----------------------------------------------------------------------------
  // hw minimum interval guard
  // ----------------------------------------------------------------------------
  reg [`CNT_W-1:0] gap_cnt_reg;
  wire             gap_ok = (gap_cnt_reg >= MIN_INTERVAL_CYC_IN);

  // ----------------------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------------------
  reg trig;
  always @* begin
    case (TRIG_SRC_IN) // [R01]
      `SRC_TIMER: trig = timer_tick;
      `SRC_CMD:   trig = ETH_CMD_TRIG_IN | SER_CMD_TRIG_IN; // [R11]
      `SRC_HW:    trig = hw_edge & gap_ok; // [R06]
      default:    trig = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // ping sequencer
  // ----------------------------------------------------------------------------
  reg  [2:0]        state_reg;
  reg  [2:0]        state_next;
  reg  [`CNT_W-1:0] cnt_reg;
  reg  [`ILV_W-1:0] ilv_reg;
  reg  [`CNT_W-1:0] lamp_reg;
  reg               measuring_reg;
  reg               boot_pend_reg;
  wire [`CNT_W-1:0] tx_cap = LOW_FREQ_VARIANT_IN ? TX_MAX_LO_CYC_P : TX_MAX_HI_CYC_P;
  // bottom distance sets the requested length; the variant cap still bounds it
  wire [`CNT_W-1:0] tx_len = (TX_LEN_CYC_IN > tx_cap) ? tx_cap : TX_LEN_CYC_IN; // [R09]
  wire [`CNT_W-1:0] rx_len = (RX_LEN_CYC_IN == {`CNT_W{1'b0}}) ? 32'h1 : RX_LEN_CYC_IN;
  wire              accept = (state_reg == ST_IDLE) && measuring_reg && trig;
  wire              cnt_done = (cnt_reg <= 32'h1);
  // a ratio below two would make every ping a profile and starve bottom track
  wire [`ILV_W-1:0] ilv_n = (ILV_RATIO_IN < 4'h2) ? 4'h2 : ILV_RATIO_IN;
  wire              next_profile = PROFILE_EN_IN && (ilv_reg + 4'h1 >= ilv_n); // [R12]

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (accept) state_next = ST_DELAY; // [R04]
      ST_DELAY: if (cnt_done) state_next = (tx_len == {`CNT_W{1'b0}}) ? ST_RX : ST_TX; // [R08]
      ST_TX:    if (cnt_done) state_next = ST_RX;
      ST_RX:    if (cnt_done) state_next = ST_IDLE; // [R04]
      ST_PAUSE: if (cnt_done) state_next = ST_IDLE; // [R19]
      default:  state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------------
  // power-up resume and measuring state
  // ----------------------------------------------------------------------------
  // stored state is caught after reset release, never under the reset itself
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      measuring_reg <= 1'b0;
      boot_pend_reg <= 1'b1;
    end else if (boot_pend_reg) begin
      measuring_reg <= STORED_MEASURE_IN; // [R18]
      boot_pend_reg <= 1'b0;
    end else begin
      measuring_reg <= MEASURE_EN_IN;
    end
  end

  // ----------------------------------------------------------------------------
  // phase state and phase counter
  // ----------------------------------------------------------------------------
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= {`CNT_W{1'b0}};
    end else if (boot_pend_reg) begin
      // a resumed run first sits out the network check
      if (STORED_MEASURE_IN) begin
        state_reg <= ST_PAUSE; // [R19]
        cnt_reg   <= RESUME_PAUSE_CYC_P;
      end
    end else begin
      state_reg <= state_next;
      case (state_reg)
        ST_IDLE: begin
          if (accept)
            cnt_reg <= TX_DELAY_CYC_P; // [R08]
        end
        ST_DELAY: begin
          if (cnt_done)
            cnt_reg <= (tx_len == {`CNT_W{1'b0}}) ? rx_len : tx_len; // [R09]
          else
            cnt_reg <= cnt_reg - 32'h1;
        end
        ST_TX: begin
          if (cnt_done)
            cnt_reg <= rx_len; // [R04]
          else
            cnt_reg <= cnt_reg - 32'h1;
        end
        default: begin
          if (!cnt_done)
            cnt_reg <= cnt_reg - 32'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // hw gap counter
  // ----------------------------------------------------------------------------
  // the count stops at the limit, so a long quiet spell cannot wrap it
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      gap_cnt_reg <= {`CNT_W{1'b0}};
    else if (accept)
      gap_cnt_reg <= {`CNT_W{1'b0}}; // [R06]
    else if (!gap_ok)
      gap_cnt_reg <= gap_cnt_reg + 32'h1;
  end

  // ----------------------------------------------------------------------------
  // interleave counter
  // ----------------------------------------------------------------------------
  // profiling off restarts the count, so the first ping after enabling is bottom track
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      ilv_reg <= {`ILV_W{1'b0}};
    else if (!PROFILE_EN_IN)
      ilv_reg <= {`ILV_W{1'b0}};
    else if (accept)
      ilv_reg <= next_profile ? {`ILV_W{1'b0}} : ilv_reg + 4'h1; // [R12]
  end

  // ----------------------------------------------------------------------------
  // indicator lamp timer
  // ----------------------------------------------------------------------------
  // restarted by every accepted ping; pings closer than the on time merge into one glow
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      lamp_reg <= {`CNT_W{1'b0}};
    else if (accept)
      lamp_reg <= LAMP_ON_CYC_P; // [R17]
    else if (lamp_reg != {`CNT_W{1'b0}})
      lamp_reg <= lamp_reg - 32'h1;
  end

  // ----------------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------------
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      TX_ACTIVE_OUT    <= 1'b0;
      RX_ACTIVE_OUT    <= 1'b0;
      PING_BUSY_OUT    <= 1'b0;
      PING_START_OUT   <= 1'b0;
    end else begin
      TX_ACTIVE_OUT    <= (state_next == ST_TX);
      RX_ACTIVE_OUT    <= (state_next == ST_RX);
      PING_BUSY_OUT    <= (state_next == ST_DELAY) || (state_next == ST_TX) ||
                          (state_next == ST_RX);
      PING_START_OUT   <= accept;
    end
  end

  // ----------------------------------------------------------------------------
  // per-ping type and transmit power
  // ----------------------------------------------------------------------------
  // type latched per ping; profile and bottom never together
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      PROFILE_PING_OUT <= 1'b0;
      BOTTOM_PING_OUT  <= 1'b0;
      WATER_TRACK_OUT  <= 1'b0;
      TX_PWR_DB_OUT    <= {`PWR_W{1'b0}};
    end else if (accept) begin
      PROFILE_PING_OUT <= next_profile; // [R12]
      BOTTOM_PING_OUT  <= ~next_profile;
      WATER_TRACK_OUT  <= ~next_profile & WATER_TRACK_EN_IN; // [R13]
      TX_PWR_DB_OUT    <= PWR_AUTO_IN ? PWR_MAX_DB_IN : PWR_USER_DB_IN; // [R16]
    end
  end

  // ----------------------------------------------------------------------------
  // recorder control
  // ----------------------------------------------------------------------------
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      REC_WRITE_EN_OUT <= 1'b0;
      REC_APPEND_OUT   <= 1'b0;
    end else begin
      REC_WRITE_EN_OUT <= REC_EN_IN & ~STORAGE_FULL_IN; // [R15]
      REC_APPEND_OUT   <= REC_EN_IN & FILE_EXISTS_IN; // [R14]
    end
  end

  // ----------------------------------------------------------------------------
  // lamp, measuring and drop status
  // ----------------------------------------------------------------------------
  // a drop is only flagged while measuring, so a stopped unit stays quiet
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      LAMP_OUT         <= 1'b0;
      MEASURING_OUT    <= 1'b0;
      TRIG_DROPPED_OUT <= 1'b0;
    end else begin
      LAMP_OUT         <= measuring_reg && (lamp_reg != {`CNT_W{1'b0}}); // [R17]
      MEASURING_OUT    <= measuring_reg;
      TRIG_DROPPED_OUT <= trig && measuring_reg && (state_reg != ST_IDLE); // [R05]
    end
  end

endmodule // ping_trigger_scheduler

//--- design/ping_sched_consts.vh
// constants for the ping trigger scheduler
`ifndef PING_SCHED_CONSTS_VH
`define PING_SCHED_CONSTS_VH
// clock rate
`define CLK_HZ           25000000
// trigger source encodings
`define SRC_TIMER        2'h0
`define SRC_CMD          2'h1
`define SRC_HW           2'h2
// edge selections
`define EDGE_RISE        2'h0
`define EDGE_FALL        2'h1
`define EDGE_BOTH        2'h2
// timing, in microseconds as printed, then derived counts
`define TX_DELAY_US      8400
`define TX_MAX_HI_US     13300
`define TX_MAX_LO_US     26600
`define RESUME_PAUSE_US  1500000
`define TX_DELAY_CYC     ((`TX_DELAY_US * (`CLK_HZ / 1000000)))
`define TX_MAX_HI_CYC    ((`TX_MAX_HI_US * (`CLK_HZ / 1000000)))
`define TX_MAX_LO_CYC    ((`TX_MAX_LO_US * (`CLK_HZ / 1000000)))
`define RESUME_PAUSE_CYC ((`RESUME_PAUSE_US * (`CLK_HZ / 1000000)))
// lamp on time
`define LAMP_ON_CYC      32'h0007a120
// widths
`define CNT_W            32
`define RATE_W           4
`define ILV_W            4
`define PWR_W            8
`define SYNC_STAGES      3
`endif

//--- verification/ping_sched_props.sv
// concurrent checks on the ping trigger scheduler ports
`timescale 1ns/10ps
module ping_sched_props #(
  parameter [31:0] TX_DELAY_CYC_P  = 32'h14,
  parameter [31:0] TX_MAX_HI_CYC_P = 32'h1e,
  parameter [31:0] TX_MAX_LO_CYC_P = 32'h3c
) (
  input wire logic       CLK_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       LOW_FREQ_VARIANT_IN,
  input wire logic       REC_EN_IN,
  input wire logic       FILE_EXISTS_IN,
  input wire logic       STORAGE_FULL_IN,
  input wire logic       TX_ACTIVE_OUT,
  input wire logic       RX_ACTIVE_OUT,
  input wire logic       PING_BUSY_OUT,
  input wire logic       PING_START_OUT,
  input wire logic       PROFILE_PING_OUT,
  input wire logic       BOTTOM_PING_OUT,
  input wire logic       WATER_TRACK_OUT,
  input wire logic       REC_WRITE_EN_OUT,
  input wire logic       REC_APPEND_OUT
);
  // ----------------------------------------
  // transmit run length, cleared between runs
  // ----------------------------------------
  logic [31:0] tx_run_reg;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) tx_run_reg <= 32'h0;
    else tx_run_reg <= TX_ACTIVE_OUT ? tx_run_reg + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  chk_start_one_cycle: assert property (PING_START_OUT |=> !PING_START_OUT)
    else $error("start pulse too long");
  chk_start_from_idle: assert property (PING_START_OUT |-> PING_BUSY_OUT && !$past(PING_BUSY_OUT))
    else $error("ping started while busy");
  chk_tx_latency: assert property ($rose(TX_ACTIVE_OUT) |-> $past(PING_START_OUT, TX_DELAY_CYC_P))
    else $error("transmit latency wrong");
  chk_tx_cap_len: assert property (tx_run_reg <= (LOW_FREQ_VARIANT_IN ? TX_MAX_LO_CYC_P : TX_MAX_HI_CYC_P))
    else $error("transmit longer than cap");
  chk_rx_after_tx: assert property ($fell(TX_ACTIVE_OUT) |-> RX_ACTIVE_OUT && PING_BUSY_OUT)
    else $error("receive does not follow transmit");
  chk_phase_in_busy: assert property ((TX_ACTIVE_OUT || RX_ACTIVE_OUT) |-> PING_BUSY_OUT && !(TX_ACTIVE_OUT && RX_ACTIVE_OUT))
    else $error("phase outside ping");
  chk_type_exclusive: assert property (!(PROFILE_PING_OUT && BOTTOM_PING_OUT))
    else $error("profile and bottom at once");
  chk_water_on_bottom: assert property (WATER_TRACK_OUT |-> BOTTOM_PING_OUT)
    else $error("water track without bottom ping");
  chk_rec_write_en: assert property (!$past(SYS_RST_IN) |-> REC_WRITE_EN_OUT == $past(REC_EN_IN && !STORAGE_FULL_IN))
    else $error("record write enable wrong");
  chk_rec_append_on: assert property (!$past(SYS_RST_IN) |-> REC_APPEND_OUT == $past(REC_EN_IN && FILE_EXISTS_IN))
    else $error("record append wrong");
endmodule // ping_sched_props
bind ping_trigger_scheduler ping_sched_props #(.TX_DELAY_CYC_P(TX_DELAY_CYC_P),
  .TX_MAX_HI_CYC_P(TX_MAX_HI_CYC_P), .TX_MAX_LO_CYC_P(TX_MAX_LO_CYC_P)) u_ping_sched_props (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .LOW_FREQ_VARIANT_IN(LOW_FREQ_VARIANT_IN),
  .REC_EN_IN(REC_EN_IN), .FILE_EXISTS_IN(FILE_EXISTS_IN), .STORAGE_FULL_IN(STORAGE_FULL_IN),
  .TX_ACTIVE_OUT(TX_ACTIVE_OUT), .RX_ACTIVE_OUT(RX_ACTIVE_OUT), .PING_BUSY_OUT(PING_BUSY_OUT),
  .PING_START_OUT(PING_START_OUT), .PROFILE_PING_OUT(PROFILE_PING_OUT),
  .BOTTOM_PING_OUT(BOTTOM_PING_OUT), .WATER_TRACK_OUT(WATER_TRACK_OUT),
  .REC_WRITE_EN_OUT(REC_WRITE_EN_OUT), .REC_APPEND_OUT(REC_APPEND_OUT));

//--- verification/hw_trigger_source.sv
// vehicle controller model driving the hardware trigger line
`timescale 1ns/10ps
module hw_trigger_source #(
  parameter int PULSE_CYC = 80
) (
  input  wire logic clk_in,
  input  wire logic fire_in,
  output logic      line_out
);
  int left_reg = 0;
  initial line_out = 1'b0;
  // width scaled down with the other timings, still far above the synchroniser depth
  always @(posedge clk_in) begin
    line_out <= fire_in || left_reg > 1;
    left_reg <= fire_in ? PULSE_CYC : (left_reg > 0 ? left_reg - 1 : 0);
  end
endmodule // hw_trigger_source

//--- verification/tb_ping_trigger_scheduler.sv
// self-checking bench for the ping trigger scheduler
`timescale 1ns/10ps
`include "ping_sched_consts.vh"
module tb_ping_trigger_scheduler;
  logic clk = 1'b0, rst = 1'b1, meas = 1'b0, stored = 1'b0, eth = 1'b0, ser = 1'b0, fire = 1'b0;
  logic lowf = 1'b0, prof = 1'b0, wt = 1'b0, rec = 1'b0, fex = 1'b0, full = 1'b0, pauto = 1'b0;
  logic [1:0]  src = 2'h3, esel = 2'h3;
  logic [3:0]  rate = 4'h1, ilv = 4'h2;
  logic [31:0] min_int = 32'h0, tx_len = 32'ha, rx_len = 32'ha;
  logic [7:0]  puser = 8'hf6, pmax = 8'hfe;
  wire         hw, tx, rx, busy, start, po, bo, wo, rw, ra, lamp, msr, drop;
  wire  [7:0]  pwr;
  int          errors = 0, n_checks = 0, n_starts = 0, n_drops = 0, n0, d0;
  int          tx_cyc = 0, rx_cyc = 0;
  always #20 clk = ~clk;
  hw_trigger_source #(.PULSE_CYC(80)) u_hw_trigger_source (.clk_in(clk), .fire_in(fire),
    .line_out(hw));
  ping_trigger_scheduler #(.TX_DELAY_CYC_P(32'h14), .TX_MAX_HI_CYC_P(32'h1e),
    .TX_MAX_LO_CYC_P(32'h3c), .RESUME_PAUSE_CYC_P(32'h32), .LAMP_ON_CYC_P(32'ha),
    .SECOND_CYC_P(32'h320)) u_ping_trigger_scheduler (.CLK_IN(clk), .SYS_RST_IN(rst),
    .MEASURE_EN_IN(meas), .STORED_MEASURE_IN(stored), .TRIG_SRC_IN(src), .SAMPLE_RATE_IN(rate),
    .EDGE_SEL_IN(esel), .HW_TRIG_IN(hw), .ETH_CMD_TRIG_IN(eth), .SER_CMD_TRIG_IN(ser),
    .MIN_INTERVAL_CYC_IN(min_int), .LOW_FREQ_VARIANT_IN(lowf), .TX_LEN_CYC_IN(tx_len),
    .RX_LEN_CYC_IN(rx_len), .PROFILE_EN_IN(prof), .ILV_RATIO_IN(ilv), .WATER_TRACK_EN_IN(wt),
    .REC_EN_IN(rec), .FILE_EXISTS_IN(fex), .STORAGE_FULL_IN(full), .PWR_AUTO_IN(pauto),
    .PWR_USER_DB_IN(puser), .PWR_MAX_DB_IN(pmax), .TX_ACTIVE_OUT(tx), .RX_ACTIVE_OUT(rx),
    .PING_BUSY_OUT(busy), .PING_START_OUT(start), .PROFILE_PING_OUT(po), .BOTTOM_PING_OUT(bo),
    .WATER_TRACK_OUT(wo), .REC_WRITE_EN_OUT(rw), .REC_APPEND_OUT(ra), .TX_PWR_DB_OUT(pwr),
    .LAMP_OUT(lamp), .MEASURING_OUT(msr), .TRIG_DROPPED_OUT(drop));
  always @(posedge clk) begin
    n_starts <= n_starts + (start === 1'b1);
    n_drops <= n_drops + (drop === 1'b1);
    tx_cyc <= (start === 1'b1) ? 0 : tx_cyc + (tx === 1'b1);
    rx_cyc <= (start === 1'b1) ? 0 : rx_cyc + (rx === 1'b1);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic check_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_eq(got >= lo && got <= hi, 1'b1);
  endtask
  task automatic pulse(input bit use_ser);
    @(posedge clk);
    eth <= !use_ser;
    ser <= use_ser;
    @(posedge clk);
    eth <= 1'b0;
    ser <= 1'b0;
  endtask
  task automatic wait_idle;
    cyc(2);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    cyc(2);
  endtask
  task automatic cmd_ping(input bit use_ser);
    n0 = n_starts;
    pulse(use_ser);
    cyc(3);
    check_eq(lamp, 1'b1);
    wait_idle;
    check_eq(n_starts - n0, 1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    cyc(40000);
    errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    cyc(8);
    rst <= 1'b0;
    meas <= 1'b1;
    src <= `SRC_TIMER;
    for (int r = 1; r <= 8; r += 7) begin
      rate <= 4'(r);
      cyc(10);
      n0 = n_starts;
      cyc(1600);
      check_range(n_starts - n0, 2 * r - 1, 2 * r + 1);
    end
    wait_idle;
    src <= `SRC_HW;
    n0 = n_starts;
    pulse(1'b0);
    cyc(400);
    check_eq(n_starts - n0, 0);
    for (int i = 0; i < 4; i++) begin
      esel <= (i == 3) ? `EDGE_BOTH : 2'(i);
      min_int <= (i == 3) ? 32'h3e8 : 32'h0;
      cyc(1200);
      n0 = n_starts;
      fire <= 1'b1;
      cyc(1);
      fire <= 1'b0;
      cyc(200);
      check_eq(n_starts - n0, (i == 2) ? 2 : 1);
    end
    src <= `SRC_CMD;
    n0 = n_starts;
    d0 = n_drops;
    pulse(1'b0);
    cyc(8);
    pulse(1'b1);
    wait_idle;
    cyc(30);
    check_eq(n_starts - n0, 1);
    check_eq(n_drops - d0, 1);
    for (int i = 0; i < 4; i++) begin
      lowf <= i[0];
      tx_len <= (i == 2) ? 32'ha : (i == 3) ? 32'h0 : 32'hc8;
      rx_len <= (i == 2) ? 32'h14 : 32'ha;
      cyc(2);
      cmd_ping(1'b0);
      check_eq(tx_cyc, (i == 3) ? 0 : (i == 2) ? 10 : (i == 1) ? 60 : 30);
      check_eq(rx_cyc, (i == 2) ? 20 : 10);
    end
    tx_len <= 32'ha;
    for (int r = 2; r <= 3; r++) begin
      prof <= 1'b0;
      cyc(2);
      ilv <= 4'(r);
      prof <= 1'b1;
      wt <= 1'b1;
      pauto <= (r == 2);
      puser <= (r == 2) ? 8'hf6 : 8'hec;
      for (int p = 1; p <= 6; p++) begin
        cmd_ping(p[0]);
        check_eq(po, (p % r) == 0);
        check_eq(wo, (p % r) != 0);
        check_eq(pwr, (r == 2) ? pmax : puser);
      end
    end
    rec <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      full <= i[0];
      fex <= i[1];
      cyc(3);
      check_eq(rw, !i[0]);
      check_eq(ra, i[1]);
    end
    meas <= 1'b0;
    cyc(3);
    check_eq(msr, 1'b0);
    n0 = n_starts;
    pulse(1'b0);
    cyc(40);
    check_eq(n_starts - n0, 0);
    check_eq(lamp, 1'b0);
    meas <= 1'b1;
    stored <= 1'b1;
    rst <= 1'b1;
    cyc(8);
    rst <= 1'b0;
    n0 = n_starts;
    d0 = n_drops;
    cyc(20);
    pulse(1'b0);
    cyc(20);
    check_eq(n_starts - n0, 0);
    check_eq(n_drops - d0, 1);
    cyc(10);
    cmd_ping(1'b1);
    src <= `SRC_TIMER;
    n0 = n_starts;
    cyc(250);
    check_range(n_starts - n0, 1, 4);
    check_eq(msr, 1'b1);
    tally_and_finish;
  end
endmodule // tb_ping_trigger_scheduler
